// *** logic/flow_pkg.sv ***
// Constants and types shared by the call, return and reset logic.
package flow_pkg;
   // ==========================================================
   // Widths and stack depth
   localparam int PC_W = 21;
   localparam int INSTR_W = 16;
   localparam int OFFSET_W = 11;
   localparam int STACK_DEPTH = 31;

   // ==========================================================
   // Encodings
   localparam logic [4:0] CALL_REL_TOP = 5'h1B;
   localparam logic [15:0] SOFT_RESET_WORD = 16'h00FF;
   localparam logic [14:0] INT_RETURN_TOP = 15'h0008;
   localparam logic [7:0] LIT_RETURN_TOP = 8'h0C;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

   // ==========================================================
   // Quarter cycles
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q4 = 2'h3;

   // ==========================================================
   // Register byte offsets
   localparam logic [5:0] OFS_INSTR = 6'h00;
   localparam logic [5:0] OFS_PC = 6'h04;
   localparam logic [5:0] OFS_WORK = 6'h08;
   localparam logic [5:0] OFS_FLAGS = 6'h0C;
   localparam logic [5:0] OFS_BANK = 6'h10;
   localparam logic [5:0] OFS_WORK_SH = 6'h14;
   localparam logic [5:0] OFS_FLAGS_SH = 6'h18;
   localparam logic [5:0] OFS_BANK_SH = 6'h1C;
   localparam logic [5:0] OFS_INT_CTRL = 6'h20;
   localparam logic [5:0] OFS_STACK_TOP = 6'h24;
   localparam logic [5:0] OFS_STATE = 6'h28;
   localparam logic [5:0] OFS_PC_LATCH = 6'h2C;

   // ==========================================================
   // Field positions
   localparam int INT_HIGH_BIT = 0;
   localparam int INT_LOW_BIT = 1;
   localparam int INT_PRIO_BIT = 2;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_KIND_LSB = 4;

   // ==========================================================
   // Reset values
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] INT_RST = 3'h0;

   typedef enum logic [2:0] {
      K_NONE, K_CALL_REL, K_SOFT_RESET, K_INT_RETURN, K_LIT_RETURN
   } kind_type;

   function automatic kind_type decode_kind(input logic [15:0] word);
      kind_type k;
      k = K_NONE;
      if (word[15:11] == CALL_REL_TOP) begin
         k = K_CALL_REL;
      end else if (word == SOFT_RESET_WORD) begin
         k = K_SOFT_RESET;
      end else if (word[15:1] == INT_RETURN_TOP) begin
         k = K_INT_RETURN;
      end else if (word[15:8] == LIT_RETURN_TOP) begin
         k = K_LIT_RETURN;
      end
      return k;
   endfunction

   function automatic logic two_cycles(input kind_type k);
      return (k == K_CALL_REL) || (k == K_INT_RETURN) ||
         (k == K_LIT_RETURN);
   endfunction
endpackage

// *** logic/core_link_if.sv ***
// Links between the executer, its return stack and its quarter sequencer.
`timescale 1ns/1ps
`default_nettype none
interface core_link_if;
   import flow_pkg::*;
   logic push;
   logic pop;
   logic clear;
   logic [PC_W-1:0] push_data;
   logic [PC_W-1:0] top;
   logic start;
   logic two_cyc;
   logic busy;
   logic done;
   logic [1:0] quarter;
   logic second;

   modport exec (output push, pop, clear, push_data, start, two_cyc,
      input top, busy, done, quarter, second);
   modport stack (input push, pop, clear, push_data, output top);
   modport seq (input start, two_cyc, clear, output busy, done, quarter,
      second);
endinterface
`default_nettype wire

// *** logic/return_stack.sv ***
// Hardware return stack with a registered top entry.
`timescale 1ns/1ps
`default_nettype none
module return_stack
   import flow_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   core_link_if.stack lnk
);
   localparam int PW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] ONE = PW'(1);

   logic [PC_W-1:0] mem [DEPTH];
   logic [PW-1:0] ptr_q;
   logic [PC_W-1:0] top_q;

   assign lnk.top = top_q;

   // ==========================================================
   // Entries below the top
   always_ff @(posedge clk) begin
      if (lnk.push && ptr_q < PW'(DEPTH)) begin
         mem[ptr_q] <= top_q;
      end
   end

   // ==========================================================
   // Pointer and top
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q <= '0;
         top_q <= PC_RST;
      end else if (lnk.clear) begin
         ptr_q <= '0;
         top_q <= PC_RST;
      end else if (lnk.push) begin
         // Old top moves one level down, or is dropped once all DEPTH entries below are full
         if (ptr_q < PW'(DEPTH)) begin
            ptr_q <= ptr_q + ONE;
         end
         top_q <= lnk.push_data;
      end else if (lnk.pop) begin
         // Previous entry becomes top, or PC_RST when no entry is left below
         if (ptr_q != '0) begin
            ptr_q <= ptr_q - ONE;
            top_q <= mem[ptr_q - ONE];
         end else begin
            top_q <= PC_RST;
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/quarter_seq.sv ***
// Four-quarter instruction cycle sequencer, one or two cycles long.
`timescale 1ns/1ps
`default_nettype none
module quarter_seq
   import flow_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   core_link_if.seq lnk
);
   logic busy_q;
   logic [1:0] q_q;
   logic second_q;
   logic long_q;

   assign lnk.busy = busy_q;
   assign lnk.quarter = q_q;
   assign lnk.second = second_q;
   assign lnk.done = busy_q && q_q == Q4 && (second_q || !long_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         q_q <= 2'h0;
         second_q <= 1'b0;
         long_q <= 1'b0;
      end else if (lnk.start && !busy_q) begin
         busy_q <= 1'b1;
         q_q <= 2'h0;
         second_q <= 1'b0;
         long_q <= lnk.two_cyc;
      end else if (busy_q) begin
         q_q <= q_q + 2'h1;
         if (lnk.done) begin
            busy_q <= 1'b0;
         end else if (q_q == Q4) begin
            second_q <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/call_return_reset_ops.sv ***
// Executer for relative call, soft reset and the two return instructions.
`timescale 1ns/1ps
`default_nettype none
module call_return_reset_ops
   import flow_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [PC_W-1:0] pc_out,
   output logic fetch_flush,
   output logic soft_reset
);
   core_link_if lnk ();

   logic [PC_W-1:0] pc_q;
   logic [7:0] work_q;
   logic [7:0] flags_q;
   logic [7:0] bank_q;
   logic [7:0] work_sh_q;
   logic [7:0] flags_sh_q;
   logic [7:0] bank_sh_q;
   logic [2:0] int_q;
   logic [15:0] pc_latch_q;
   logic [15:0] instr_q;
   kind_type kind_q;
   logic [31:0] readdata_q;
   logic rd_ack_q;
   logic flush_q;
   logic soft_reset_q;

   logic is_instr;
   logic wr_go;
   logic cmd_go;
   logic q2_first;
   logic q4_first;
   logic do_reset;
   logic [PC_W-1:0] ret_addr;
   logic [PC_W-1:0] rel_step;
   logic shadow_sel;
   logic wr_pc;
   logic wr_work;
   logic wr_flags;
   logic wr_bank;
   logic wr_work_sh;
   logic wr_flags_sh;
   logic wr_bank_sh;
   logic wr_int;
   logic wr_latch;

   return_stack #(.DEPTH(DEPTH)) u_stack (
      .clk(clk),
      .rst_b(rst_b),
      .lnk(lnk)
   );

   quarter_seq u_seq (
      .clk(clk),
      .rst_b(rst_b),
      .lnk(lnk)
   );

   // ==========================================================
   // Register decode
   // One compare for every register keeps the offsets in one place
   function automatic logic reg_hit(input logic [5:0] addr,
      input logic [5:0] ofs);
      return addr[5:2] == ofs[5:2];
   endfunction

   // Stack top and state are read only: writes there are dropped
   assign wr_pc = wr_go && reg_hit(avs_address, OFS_PC);
   assign wr_work = wr_go && reg_hit(avs_address, OFS_WORK);
   assign wr_flags = wr_go && reg_hit(avs_address, OFS_FLAGS);
   assign wr_bank = wr_go && reg_hit(avs_address, OFS_BANK);
   assign wr_work_sh = wr_go && reg_hit(avs_address, OFS_WORK_SH);
   assign wr_flags_sh = wr_go && reg_hit(avs_address, OFS_FLAGS_SH);
   assign wr_bank_sh = wr_go && reg_hit(avs_address, OFS_BANK_SH);
   assign wr_int = wr_go && reg_hit(avs_address, OFS_INT_CTRL);
   assign wr_latch = wr_go && reg_hit(avs_address, OFS_PC_LATCH);

   // ==========================================================
   // Bus slave
   assign is_instr = reg_hit(avs_address, OFS_INSTR);
   // Register writes wait while an instruction runs, to avoid racing it
   assign wr_go = avs_write && !lnk.busy && !is_instr;
   assign cmd_go = avs_write && is_instr && !lnk.busy;
   assign avs_waitrequest = (avs_read && !rd_ack_q) ||
      (avs_write && is_instr && !(lnk.busy && lnk.done)) ||
      (avs_write && !is_instr && lnk.busy);
   assign avs_readdata = readdata_q;

   // Data latched on the request edge, so every read costs one wait
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_ack_q <= 1'b0;
         readdata_q <= 32'h00000000;
      end else begin
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q) begin
            unique case (avs_address[5:2])
               OFS_INSTR[5:2]: readdata_q <= {16'h0000, instr_q};
               OFS_PC[5:2]: readdata_q <= {11'h000, pc_q};
               OFS_WORK[5:2]: readdata_q <= {24'h000000, work_q};
               OFS_FLAGS[5:2]: readdata_q <= {24'h000000, flags_q};
               OFS_BANK[5:2]: readdata_q <= {24'h000000, bank_q};
               OFS_WORK_SH[5:2]: readdata_q <= {24'h000000, work_sh_q};
               OFS_FLAGS_SH[5:2]: readdata_q <= {24'h000000, flags_sh_q};
               OFS_BANK_SH[5:2]: readdata_q <= {24'h000000, bank_sh_q};
               OFS_INT_CTRL[5:2]: readdata_q <= {29'h00000000, int_q};
               OFS_STACK_TOP[5:2]: readdata_q <= {11'h000, lnk.top};
               OFS_STATE[5:2]: readdata_q <= {25'h0000000, kind_q,
                  3'h0, lnk.busy};
               OFS_PC_LATCH[5:2]: readdata_q <= {16'h0000, pc_latch_q};
               default: readdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================
   // Instruction start
   assign lnk.start = cmd_go;
   assign lnk.two_cyc = two_cycles(decode_kind(avs_writedata[15:0]));
   assign q2_first = lnk.busy && !lnk.second && lnk.quarter == Q2;
   assign q4_first = lnk.busy && !lnk.second && lnk.quarter == Q4;
   // Soft reset takes effect at the end of its single cycle
   assign do_reset = q4_first && kind_q == K_SOFT_RESET;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_q <= 16'h0000;
         kind_q <= K_NONE;
      end else if (cmd_go) begin
         instr_q <= avs_writedata[15:0];
         kind_q <= decode_kind(avs_writedata[15:0]);
      end
   end

   // ==========================================================
   // Stack traffic
   assign ret_addr = pc_q + PC_STEP;
   // Offset doubled and sign extended to the PC width
   assign rel_step = {{(PC_W-OFFSET_W-1){instr_q[OFFSET_W-1]}},
      instr_q[OFFSET_W-1:0], 1'b0};
   assign lnk.push = q2_first && kind_q == K_CALL_REL;
   assign lnk.push_data = ret_addr;
   assign lnk.pop = q4_first && (kind_q == K_INT_RETURN ||
      kind_q == K_LIT_RETURN);
   assign lnk.clear = do_reset;

   // ==========================================================
   // Program counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_q <= PC_RST;
      end else if (do_reset) begin
         pc_q <= PC_RST;
      end else if (wr_pc) begin
         pc_q <= avs_writedata[PC_W-1:0];
      end else if (q4_first) begin
         unique case (kind_q)
            K_CALL_REL: pc_q <= ret_addr + rel_step;
            K_INT_RETURN: pc_q <= lnk.top;
            K_LIT_RETURN: pc_q <= lnk.top;
            default: pc_q <= ret_addr;
         endcase
      end
   end
   assign pc_out = pc_q;

   // ==========================================================
   // Work, flags and bank registers
   assign shadow_sel = instr_q[0];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         work_q <= BYTE_RST;
      end else if (do_reset) begin
         work_q <= BYTE_RST;
      end else if (wr_work) begin
         work_q <= avs_writedata[7:0];
      end else if (q4_first && kind_q == K_LIT_RETURN) begin
         work_q <= instr_q[7:0];
      end else if (q4_first && kind_q == K_INT_RETURN && shadow_sel) begin
         work_q <= work_sh_q;
      end
   end

   // Calls and literal returns leave the flags alone
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= BYTE_RST;
         bank_q <= BYTE_RST;
      end else if (do_reset) begin
         flags_q <= BYTE_RST;
         bank_q <= BYTE_RST;
      end else if (wr_go) begin
         if (wr_flags) begin
            flags_q <= avs_writedata[7:0];
         end
         if (wr_bank) begin
            bank_q <= avs_writedata[7:0];
         end
      end else if (q4_first && kind_q == K_INT_RETURN && shadow_sel) begin
         flags_q <= flags_sh_q;
         bank_q <= bank_sh_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         work_sh_q <= BYTE_RST;
         flags_sh_q <= BYTE_RST;
         bank_sh_q <= BYTE_RST;
      end else if (do_reset) begin
         work_sh_q <= BYTE_RST;
         flags_sh_q <= BYTE_RST;
         bank_sh_q <= BYTE_RST;
      end else if (wr_go) begin
         if (wr_work_sh) begin
            work_sh_q <= avs_writedata[7:0];
         end
         if (wr_flags_sh) begin
            flags_sh_q <= avs_writedata[7:0];
         end
         if (wr_bank_sh) begin
            bank_sh_q <= avs_writedata[7:0];
         end
      end
   end

   // ==========================================================
   // PC latches: only software and reset touch them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_latch_q <= 16'h0000;
      end else if (do_reset) begin
         pc_latch_q <= 16'h0000;
      end else if (wr_latch) begin
         pc_latch_q <= avs_writedata[15:0];
      end
   end

   // ==========================================================
   // Interrupt enables
   // In priority mode a set high enable means a low-level handler returns
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_q <= INT_RST;
      end else if (do_reset) begin
         int_q <= INT_RST;
      end else if (wr_int) begin
         int_q <= avs_writedata[2:0];
      end else if (q4_first && kind_q == K_INT_RETURN) begin
         if (int_q[INT_PRIO_BIT] && int_q[INT_HIGH_BIT]) begin
            int_q[INT_LOW_BIT] <= 1'b1;
         end else begin
            int_q[INT_HIGH_BIT] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Pipeline flush and reset pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flush_q <= 1'b0;
         soft_reset_q <= 1'b0;
      end else begin
         // Second cycle is idle while the new fetch lands
         flush_q <= q4_first && two_cycles(kind_q);
         soft_reset_q <= do_reset;
      end
   end
   assign fetch_flush = flush_q;
   assign soft_reset = soft_reset_q;
endmodule
`default_nettype wire

// *** verification/crr_props.sv ***
// Port-level checks for the call, return and soft reset executer.
`timescale 1ns/1ps
`default_nettype none
module crr_props
   import flow_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic fetch_flush,
   input wire logic soft_reset
);
   // ==========================================================
   // Decode of the word on the bus
   logic at_instr;
   logic is_call;
   logic is_two;
   logic is_sreset;
   logic [PC_W-1:0] call_step;
   assign at_instr = avs_write && (avs_address[5:2] == 4'h0);
   assign is_call = avs_writedata[15:11] == CALL_REL_TOP;
   assign is_two = is_call || (avs_writedata[15:8] == LIT_RETURN_TOP) ||
      (avs_writedata[15:1] == INT_RETURN_TOP);
   assign is_sreset = avs_writedata[15:0] == SOFT_RESET_WORD;
   assign call_step = PC_STEP +
      {{9{avs_writedata[10]}}, avs_writedata[10:0], 1'b0};

   // ==========================================================
   // Assertions
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest
      ##1 !avs_waitrequest) else $error("read not answered in one wait");
   a_write_idle: assert property (avs_write && !at_instr |->
      !avs_waitrequest) else $error("register write stalled while idle");
   a_two_cycle_len: assert property ($rose(avs_write) && at_instr && is_two
      |-> avs_waitrequest [*8] ##1 !avs_waitrequest)
      else $error("two-cycle instruction has wrong length");
   a_flush_at_q4: assert property ($rose(avs_write) && at_instr && is_two
      |-> !fetch_flush [*5] ##1 fetch_flush)
      else $error("flush not right after the first cycle");
   a_call_target: assert property ($rose(avs_write) && at_instr && is_call
      |-> ##5 pc_out == $past(pc_out, 5) + call_step)
      else $error("relative call target wrong");
   a_sreset_len: assert property ($rose(avs_write) && at_instr && is_sreset
      |-> avs_waitrequest [*4] ##1 !avs_waitrequest)
      else $error("soft reset is not one cycle");
   a_sreset_pulse: assert property (soft_reset |-> pc_out == PC_RST
      ##1 !soft_reset) else $error("soft reset pulse or pc wrong");
   a_flush_cause: assert property (fetch_flush |-> at_instr &&
      avs_waitrequest ##1 !fetch_flush) else $error("stray flush");
   a_pc_quiet: assert property ($changed(pc_out) |-> $past(avs_write))
      else $error("pc moved with no write");
endmodule

bind call_return_reset_ops crr_props #(.DEPTH(DEPTH)) crr_props_inst (
   .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .pc_out, .fetch_flush, .soft_reset);
`default_nettype wire

// *** verification/fetch_model.sv ***
// Fetch path model: refetches from the new pc on every flush.
`timescale 1ns/1ps
`default_nettype none
module fetch_model
   import flow_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic fetch_flush,
   input wire logic soft_reset,
   output var int flush_count,
   output var int reset_count,
   output logic [PC_W-1:0] refetch_pc
);
   // ==========================================================
   // Discard the prefetched word and fetch again at the new pc
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flush_count <= 0;
         refetch_pc <= PC_RST;
      end else if (fetch_flush) begin
         flush_count <= flush_count + 1;
         refetch_pc <= pc_out;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_count <= 0;
      end else if (soft_reset) begin
         reset_count <= reset_count + 1;
      end
   end
endmodule
`default_nettype wire

// *** verification/call_return_reset_ops_tb_top.sv ***
// Register-level test of the call, return and soft reset executer.
`timescale 1ns/1ps
`default_nettype none
module call_return_reset_ops_tb_top;
   import flow_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [PC_W-1:0] pc_out;
   logic fetch_flush;
   logic soft_reset;
   int flush_count;
   int reset_count;
   logic [PC_W-1:0] refetch_pc;
   logic [31:0] rd;
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   always #2 clk = ~clk;

   call_return_reset_ops call_return_reset_ops_inst (.clk, .rst_b,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .pc_out, .fetch_flush, .soft_reset);
   fetch_model fetch_model_inst (.clk, .rst_b, .pc_out, .fetch_flush,
      .soft_reset, .flush_count, .reset_count, .refetch_pc);

   // ==========================================================
   // Tasks
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 500);
      if (avs_waitrequest !== 1'b0) begin
         err_total++;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(rd, exp);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask

   // Generous ceiling: the whole sequence needs well under 1000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(OFS_PC, 32'h00000000);
      rdchk(OFS_INT_CTRL, 32'h00000000);
      rdchk(OFS_STACK_TOP, 32'h00000000);
      rdchk(6'h30, 32'h00000000);
      end_test("reset values");
      bus(1'b1, OFS_PC, 32'h00001000);
      bus(1'b1, OFS_FLAGS, 32'h0000005A);
      bus(1'b1, OFS_PC_LATCH, 32'h00001234);
      bus(1'b1, OFS_INSTR, 32'h0000DC00);
      rdchk(OFS_PC, 32'h00000802);
      rdchk(OFS_STACK_TOP, 32'h00001002);
      check({11'h000, refetch_pc}, 32'h00000802);
      bus(1'b1, OFS_INSTR, 32'h0000DBFF);
      rdchk(OFS_PC, 32'h00001002);
      rdchk(OFS_STACK_TOP, 32'h00000804);
      rdchk(OFS_FLAGS, 32'h0000005A);
      end_test("relative call");
      bus(1'b1, OFS_INSTR, 32'h00000CFF);
      rdchk(OFS_WORK, 32'h000000FF);
      rdchk(OFS_PC, 32'h00000804);
      rdchk(OFS_STACK_TOP, 32'h00001002);
      rdchk(OFS_PC_LATCH, 32'h00001234);
      rdchk(OFS_FLAGS, 32'h0000005A);
      end_test("literal return");
      bus(1'b1, OFS_WORK_SH, 32'h00000011);
      bus(1'b1, OFS_FLAGS_SH, 32'h00000022);
      bus(1'b1, OFS_BANK_SH, 32'h00000033);
      bus(1'b1, OFS_INSTR, 32'h00000011);
      rdchk(OFS_PC, 32'h00001002);
      rdchk(OFS_WORK, 32'h00000011);
      rdchk(OFS_FLAGS, 32'h00000022);
      rdchk(OFS_BANK, 32'h00000033);
      rdchk(OFS_INT_CTRL, 32'h00000001);
      rdchk(OFS_PC_LATCH, 32'h00001234);
      bus(1'b1, OFS_INSTR, 32'h0000D800);
      bus(1'b1, OFS_WORK, 32'h00000077);
      bus(1'b1, OFS_INT_CTRL, 32'h00000005);
      bus(1'b1, OFS_INSTR, 32'h00000010);
      rdchk(OFS_PC, 32'h00001004);
      rdchk(OFS_WORK, 32'h00000077);
      rdchk(OFS_INT_CTRL, 32'h00000007);
      check(flush_count, 32'h00000006);
      end_test("interrupt return");
      bus(1'b1, OFS_INSTR, 32'h000000FF);
      rdchk(OFS_PC, 32'h00000000);
      rdchk(OFS_WORK, 32'h00000000);
      rdchk(OFS_BANK_SH, 32'h00000000);
      rdchk(OFS_INT_CTRL, 32'h00000000);
      rdchk(OFS_PC_LATCH, 32'h00000000);
      check(reset_count, 32'h00000001);
      end_test("soft reset");
      bus(1'b1, OFS_STACK_TOP, 32'h00000055);
      rdchk(OFS_STACK_TOP, 32'h00000000);
      bus(1'b1, 6'h3C, 32'h000000FF);
      rdchk(6'h3C, 32'h00000000);
      end_test("refused writes");
      give_verdict();
   end
endmodule
`default_nettype wire
